// ===== core/csd_ctrl_decoder.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.svh"
module csd_ctrl_decoder (
    input wire logic CLOCK, // 50 MHz clock
    input wire logic RST, // sync reset, active high
    input wire logic BOUNDARY_SCAN_SELECT_N, // low: test mode
    input wire logic [1:0] CTRL_SOURCE_SEL, // control source pins
    input wire logic [1:0] OUTPUT_MODE_SEL, // interface type pins
    input wire logic [11:0] MULTIFUNCTION_PINS, // strap pins
    input wire logic [7:0] REG_ADDR, // register address
    input wire logic [7:0] REG_WDATA, // write data
    input wire logic REG_WR, // write strobe
    input wire logic REG_RD, // read strobe
    output logic [7:0] REG_RDATA, // read data, cycle after strobe
    output logic [1:0] CONTROL_MODE, // decoded mode code
    output logic JTAG_MODE, // test mode active
    output logic HARDWIRED_MODE, // strap mode active
    output logic [1:0] INTERFACE_TYPE, // output interface type
    output logic INTERFACE_UNSUPPORTED, // select pins at 10b
    output logic [3:0] LINE_RATE, // line rate code, all channels
    output logic PREEMPHASIS_EN, // pre-emphasis on
    output logic EQUALIZER_EN, // input equalization on
    output logic RETIMER_BYPASS, // retimers bypassed, powered down
    output logic CLOCK_INVERT, // recovered clock inverted
    output logic [2*`CSD_NCH-1:0] SWING_LEVEL, // 2-bit code per channel
    output logic [11*`CSD_NCH-1:0] SWING_MV, // mV per channel
    output logic [`CSD_NCH-1:0] DATA_OUT_EN, // data output on
    output logic [`CSD_NCH-1:0] DATA_INVERT, // data polarity flip
    output logic [`CSD_NCH-1:0] CLOCK_OUT_EN // clock output on
);
    csd_pkg::csd_state_t s_reg;
    csd_pkg::csd_state_t s_next;
    logic [`CSD_NCH-1:0][10:0] lvl_mv;
    logic [2:0] wr_hit;

    // {hit, channel} for the per-channel output control block
    function automatic logic [2:0] octl_hit(input logic [7:0] a);
        logic [7:0] d;
        d = a - `CSD_OFF_OCTL0;
        octl_hit = {d < 8'(`CSD_NCH), d[1:0]};
    endfunction

    function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                          input csd_pkg::csd_state_t st);
        logic [2:0] h;
        h = octl_hit(a);
        rd_mux = 8'h00;
        if (h[2]) begin
            rd_mux = st.octl[h[1:0]];
        end else begin
            case (a)
                `CSD_OFF_GCTL: rd_mux = st.gctl;
                `CSD_OFF_GCTL2: rd_mux = st.gctl2;
                `CSD_OFF_STATUS: rd_mux = {3'h0, st.iface_bad,
                                           st.iface, st.mode};
                `CSD_OFF_STRAP_LO: rd_mux = st.strap[7:0];
                `CSD_OFF_STRAP_HI: rd_mux = {4'h0, st.strap[11:8]};
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction

    // one level map per channel, fed from the registered code
    // so the mV value trails the swing code by one cycle
    generate
        for (genvar g = 0; g < `CSD_NCH; g++) begin : g_lvl
            csd_level_map u_map (
                .IFACE(s_reg.iface),
                .CODE(s_reg.swing[g]),
                .MV(lvl_mv[g])
            );
        end
    endgenerate

    assign wr_hit = octl_hit(REG_ADDR);

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        s_next.mv = lvl_mv;

        if (!BOUNDARY_SCAN_SELECT_N) begin
            s_next.mode = csd_pkg::CSD_M_JTAG;
        end else begin
            case (CTRL_SOURCE_SEL)
                `CSD_CTRL_HARD: s_next.mode = csd_pkg::CSD_M_HARD;
                `CSD_CTRL_TWO: s_next.mode = csd_pkg::CSD_M_TWO;
                `CSD_CTRL_FOUR: s_next.mode = csd_pkg::CSD_M_FOUR;
                // undefined source code kept on register control
                default: s_next.mode = csd_pkg::CSD_M_FOUR;
            endcase
        end

        // type is never writable by software
        s_next.iface = csd_pkg::csd_iface_t'(OUTPUT_MODE_SEL);
        s_next.iface_bad = (OUTPUT_MODE_SEL == `CSD_OUTSEL_BAD);

        // straps sampled once, on the first cycle after reset release
        if (s_reg.load) begin
            s_next.strap = MULTIFUNCTION_PINS;
            s_next.load = 1'b0;
        end

        if (REG_WR) begin
            if (wr_hit[2]) begin
                s_next.octl[wr_hit[1:0]] = REG_WDATA;
            end else if (REG_ADDR == `CSD_OFF_GCTL) begin
                s_next.gctl = REG_WDATA;
            end else if (REG_ADDR == `CSD_OFF_GCTL2) begin
                s_next.gctl2 = REG_WDATA;
            end
        end
        if (REG_RD) begin
            s_next.rdata = rd_mux(REG_ADDR, s_reg);
        end

        if (s_next.mode == csd_pkg::CSD_M_HARD) begin
            s_next.rate = s_reg.strap[`CSD_MF_RATE_HI:0];
            s_next.pre = !s_reg.strap[`CSD_MF_PRE];
            s_next.clk_inv = !s_reg.strap[`CSD_MF_CLKINV];
            s_next.eq = !s_reg.strap[`CSD_MF_EQ];
            s_next.byp = !s_reg.strap[`CSD_MF_BYP];
            for (int i = 0; i < `CSD_NCH; i++) begin
                s_next.swing[i] =
                    s_reg.strap[`CSD_MF_LVL_HI:`CSD_MF_LVL_LO];
                s_next.dat_en[i] =
                    (s_next.swing[i] != `CSD_SWING_OFF);
                s_next.dat_inv[i] = !s_reg.strap[`CSD_MF_DINV];
                s_next.clk_en[i] = !s_reg.strap[`CSD_MF_CLK] &&
                    (s_next.swing[i] != `CSD_SWING_OFF);
            end
        end else begin
            // post-write values, so a write takes effect next cycle
            s_next.rate = s_next.gctl[`CSD_GCTL_RATE_HI:0];
            s_next.pre = s_next.gctl[`CSD_GCTL_PRE];
            s_next.clk_inv = s_next.gctl[`CSD_GCTL_CLKINV];
            s_next.eq = s_next.gctl[`CSD_GCTL_EQ];
            s_next.byp = s_next.gctl2[`CSD_GCTL2_BYP];
            for (int i = 0; i < `CSD_NCH; i++) begin
                s_next.swing[i] = s_next.octl[i]
                    [`CSD_OCTL_SW_HI:`CSD_OCTL_SW_LO];
                s_next.dat_en[i] = s_next.octl[i][`CSD_OCTL_EN] &&
                    (s_next.swing[i] != `CSD_SWING_OFF);
                s_next.dat_inv[i] = s_next.octl[i][`CSD_OCTL_INV];
                s_next.clk_en[i] = s_next.gctl[`CSD_GCTL_CLKEN] &&
                    (s_next.swing[i] != `CSD_SWING_OFF);
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.load <= 1'b1;
            s_reg.octl <= {`CSD_NCH{`CSD_OCTL_RST}};
            s_reg.gctl <= `CSD_GCTL_RST;
            s_reg.gctl2 <= `CSD_GCTL2_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign REG_RDATA = s_reg.rdata;
    assign CONTROL_MODE = s_reg.mode;
    assign JTAG_MODE = (s_reg.mode == csd_pkg::CSD_M_JTAG);
    assign HARDWIRED_MODE = (s_reg.mode == csd_pkg::CSD_M_HARD);
    assign INTERFACE_TYPE = s_reg.iface;
    assign INTERFACE_UNSUPPORTED = s_reg.iface_bad;
    assign LINE_RATE = s_reg.rate;
    assign PREEMPHASIS_EN = s_reg.pre;
    assign EQUALIZER_EN = s_reg.eq;
    assign RETIMER_BYPASS = s_reg.byp;
    assign CLOCK_INVERT = s_reg.clk_inv;
    assign SWING_LEVEL = s_reg.swing;
    assign SWING_MV = s_reg.mv;
    assign DATA_OUT_EN = s_reg.dat_en;
    assign DATA_INVERT = s_reg.dat_inv;
    assign CLOCK_OUT_EN = s_reg.clk_en;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    property p_jtag_override;
        !$past(RST) && !$past(BOUNDARY_SCAN_SELECT_N) |-> JTAG_MODE &&
            !HARDWIRED_MODE;
    endproperty
    a_jtag_override: assert property (p_jtag_override)
        else $error("low scan select did not force test mode");

    property p_ctrl_hard;
        !$past(RST) && $past(BOUNDARY_SCAN_SELECT_N) &&
            $past(CTRL_SOURCE_SEL) == `CSD_CTRL_HARD |-> HARDWIRED_MODE;
    endproperty
    a_ctrl_hard: assert property (p_ctrl_hard)
        else $error("source 11b did not select hardwired mode");

    property p_ctrl_two;
        $past(BOUNDARY_SCAN_SELECT_N) &&
            $past(CTRL_SOURCE_SEL) == `CSD_CTRL_TWO && !$past(RST)
            |-> CONTROL_MODE == csd_pkg::CSD_M_TWO;
    endproperty
    a_ctrl_two: assert property (p_ctrl_two)
        else $error("source 01b did not select two-wire mode");

    property p_iface_pins;
        !$past(RST) |-> INTERFACE_TYPE == $past(OUTPUT_MODE_SEL);
    endproperty
    a_iface_pins: assert property (p_iface_pins)
        else $error("interface type not taken from its pins");

    property p_off_zero;
        SWING_LEVEL[1:0] == `CSD_SWING_OFF |->
            (!DATA_OUT_EN[0] && !CLOCK_OUT_EN[0]) ##1
            SWING_MV[10:0] == 11'h000;
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("swing code 00b left channel 0 on");

    sequence s_oct0_wr;
        REG_WR && REG_ADDR == `CSD_OFF_OCTL0 ##1 !HARDWIRED_MODE;
    endsequence

    property p_serial_swing;
        s_oct0_wr |-> SWING_LEVEL[1:0] == $past(REG_WDATA[7:6]);
    endproperty
    a_serial_swing: assert property (p_serial_swing)
        else $error("register swing code not applied");

    property p_serial_en;
        s_oct0_wr |-> DATA_OUT_EN[0] ==
            ($past(REG_WDATA[2]) && $past(REG_WDATA[7:6]) != 2'h0);
    endproperty
    a_serial_en: assert property (p_serial_en)
        else $error("register data enable not applied");

    property p_serial_inv;
        s_oct0_wr |-> DATA_INVERT[0] == $past(REG_WDATA[3]);
    endproperty
    a_serial_inv: assert property (p_serial_inv)
        else $error("register data invert not applied");

    property p_strap_rate;
        $fell(RST) ##2 HARDWIRED_MODE |->
            LINE_RATE == $past(MULTIFUNCTION_PINS[3:0], 2);
    endproperty
    a_strap_rate: assert property (p_strap_rate)
        else $error("line rate not taken from straps after reset");

    property p_hw_enables;
        !$past(RST) && !$past(s_reg.load) && HARDWIRED_MODE |->
            PREEMPHASIS_EN == !s_reg.strap[`CSD_MF_PRE] &&
            EQUALIZER_EN == !s_reg.strap[`CSD_MF_EQ] &&
            RETIMER_BYPASS == !s_reg.strap[`CSD_MF_BYP];
    endproperty
    a_hw_enables: assert property (p_hw_enables)
        else $error("active-low enable straps decoded wrong");

    property p_hw_polarity;
        !$past(RST) && !$past(s_reg.load) && HARDWIRED_MODE |->
            CLOCK_INVERT == !s_reg.strap[`CSD_MF_CLKINV] &&
            DATA_INVERT == {`CSD_NCH{!s_reg.strap[`CSD_MF_DINV]}};
    endproperty
    a_hw_polarity: assert property (p_hw_polarity)
        else $error("polarity straps decoded wrong");

    property p_hw_clock;
        !$past(RST) && !$past(s_reg.load) && HARDWIRED_MODE |->
            SWING_LEVEL[1:0] == s_reg.strap[9:8] &&
            CLOCK_OUT_EN[0] == (!s_reg.strap[`CSD_MF_CLK] &&
            s_reg.strap[9:8] != 2'h0);
    endproperty
    a_hw_clock: assert property (p_hw_clock)
        else $error("clock or level strap decoded wrong");

    property p_serial_global;
        REG_WR && REG_ADDR == `CSD_OFF_GCTL ##1 !HARDWIRED_MODE |->
            LINE_RATE == $past(REG_WDATA[3:0]) &&
            PREEMPHASIS_EN == $past(REG_WDATA[4]);
    endproperty
    a_serial_global: assert property (p_serial_global)
        else $error("register settings ignored outside hardwired mode");

    property p_ctrl_four;
        !$past(RST) && $past(BOUNDARY_SCAN_SELECT_N) &&
            $past(CTRL_SOURCE_SEL) == `CSD_CTRL_FOUR
            |-> CONTROL_MODE == csd_pkg::CSD_M_FOUR;
    endproperty
    a_ctrl_four: assert property (p_ctrl_four)
        else $error("source 00b did not select four-wire mode");

    property p_iface_flag;
        !$past(RST) |-> INTERFACE_UNSUPPORTED ==
            ($past(OUTPUT_MODE_SEL) == `CSD_OUTSEL_BAD);
    endproperty
    a_iface_flag: assert property (p_iface_flag)
        else $error("unsupported interface flag wrong");

    // status read mirrors the decoded outputs of the read cycle
    property p_status_rd;
        REG_RD && REG_ADDR == `CSD_OFF_STATUS |=> REG_RDATA ==
            {3'h0, $past(INTERFACE_UNSUPPORTED), $past(INTERFACE_TYPE),
            $past(CONTROL_MODE)};
    endproperty
    a_status_rd: assert property (p_status_rd)
        else $error("status read disagrees with decoded mode");

    property p_octl_rd;
        REG_RD && REG_ADDR == `CSD_OFF_OCTL0 && !HARDWIRED_MODE |=>
            REG_RDATA[7:6] == $past(SWING_LEVEL[1:0]) &&
            REG_RDATA[3] == $past(DATA_INVERT[0]);
    endproperty
    a_octl_rd: assert property (p_octl_rd)
        else $error("channel 0 outputs disagree with its register");

    // straps frozen after the capture cycle until the next reset
    property p_strap_hold;
        !$past(RST) && !$past(s_reg.load) |-> $stable(s_reg.strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("straps resampled after reset capture");

    property p_hw_steady;
        !$past(RST, 2) && !$past(s_reg.load, 2) && $past(HARDWIRED_MODE)
            && HARDWIRED_MODE |-> $stable(LINE_RATE) &&
            $stable(SWING_LEVEL);
    endproperty
    a_hw_steady: assert property (p_hw_steady)
        else $error("hardwired settings moved without a reset");

    property p_serial_bypass;
        REG_WR && REG_ADDR == `CSD_OFF_GCTL2 ##1 !HARDWIRED_MODE |->
            RETIMER_BYPASS == $past(REG_WDATA[`CSD_GCTL2_BYP]);
    endproperty
    a_serial_bypass: assert property (p_serial_bypass)
        else $error("register bypass ignored outside hardwired mode");

    property p_serial_eq;
        REG_WR && REG_ADDR == `CSD_OFF_GCTL ##1 !HARDWIRED_MODE |->
            EQUALIZER_EN == $past(REG_WDATA[`CSD_GCTL_EQ]) &&
            CLOCK_INVERT == $past(REG_WDATA[`CSD_GCTL_CLKINV]);
    endproperty
    a_serial_eq: assert property (p_serial_eq)
        else $error("register equalizer or clock invert ignored");

    c_hard: cover property (!$past(RST) && HARDWIRED_MODE ##1 HARDWIRED_MODE);
    c_jtag: cover property (JTAG_MODE ##1 !JTAG_MODE);
    c_swing_wr: cover property (s_oct0_wr);
    c_bad_if: cover property (INTERFACE_UNSUPPORTED);
    c_rd_status: cover property (REG_RD && REG_ADDR == `CSD_OFF_STATUS
        ##1 REG_RDATA != 8'h00);
endmodule
`default_nettype wire

// ===== core/csd_defs.svh
// Behaviour
// - boundary-scan select low forces test mode, ignoring control source pins
// - select high: source 11b hardwired, 00b four-wire serial, 01b two-wire serial
// - output interface type comes only from its pins: 00b CML, 01b LVDS, 11b high-swing
// - swing code 00b turns outputs off; 01b..11b give rising swing levels
// - serial modes take per-channel swing from output control bits 7:6
// - serial modes enable channel data output from output control bit 2, default on
// - serial modes invert channel data when output control bit 3 set, default off
// - hardwired mode takes its configuration from straps after power-up reset
// - hardwired mode: multifunction pins 3:0 give line rate for all channels
// - hardwired: pre-emphasis strap low enables, high or floating disables
// - hardwired: clock strap low enables all clocks at data swing, high turns off
// - hardwired: clock polarity strap low inverts clock, high keeps standard
// - hardwired: data polarity strap low inverts data, high keeps standard
// - hardwired: equalizer strap low enables equalization, high disables
// - hardwired: bypass strap low bypasses and powers down retimers, high enables
// - hardwired: pins 9:8 give swing code, 00b disables outputs, float gives 11b
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

`define CSD_NCH 4

`define CSD_OFF_OCTL0 8'h00
`define CSD_OFF_GCTL 8'h04
`define CSD_OFF_GCTL2 8'h05
`define CSD_OFF_STATUS 8'h06
`define CSD_OFF_STRAP_LO 8'h07
`define CSD_OFF_STRAP_HI 8'h08

`define CSD_OCTL_RST 8'hc4
`define CSD_GCTL_RST 8'h00
`define CSD_GCTL2_RST 8'h00

`define CSD_OCTL_SW_HI 7
`define CSD_OCTL_SW_LO 6
`define CSD_OCTL_INV 3
`define CSD_OCTL_EN 2
`define CSD_GCTL_RATE_HI 3
`define CSD_GCTL_PRE 4
`define CSD_GCTL_CLKEN 5
`define CSD_GCTL_CLKINV 6
`define CSD_GCTL_EQ 7
`define CSD_GCTL2_BYP 0

`define CSD_MF_RATE_HI 3
`define CSD_MF_PRE 4
`define CSD_MF_CLK 5
`define CSD_MF_CLKINV 6
`define CSD_MF_DINV 7
`define CSD_MF_LVL_LO 8
`define CSD_MF_LVL_HI 9
`define CSD_MF_EQ 10
`define CSD_MF_BYP 11

`define CSD_CTRL_FOUR 2'h0
`define CSD_CTRL_TWO 2'h1
`define CSD_CTRL_HARD 2'h3
`define CSD_OUTSEL_BAD 2'h2
`define CSD_SWING_OFF 2'h0

// swing levels in mV
`define CSD_MV_OFF 11'h000
`define CSD_MV_550 11'h226
`define CSD_MV_900 11'h384
`define CSD_MV_1200 11'h4b0
`define CSD_MV_450 11'h1c2
`define CSD_MV_650 11'h28a
`define CSD_MV_1000 11'h3e8
`define CSD_MV_1500 11'h5dc

`endif

// ===== core/csd_level_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.svh"
module csd_level_map (
    input wire csd_pkg::csd_iface_t IFACE, // interface type
    input wire logic [1:0] CODE, // swing code
    output logic [10:0] MV // swing in mV, zero when off
);
    always_comb begin
        MV = `CSD_MV_OFF;
        case (IFACE)
            csd_pkg::CSD_IF_CML: begin
                case (CODE)
                    2'h1: MV = `CSD_MV_550;
                    2'h2: MV = `CSD_MV_900;
                    2'h3: MV = `CSD_MV_1200;
                    default: MV = `CSD_MV_OFF;
                endcase
            end
            csd_pkg::CSD_IF_LVDS: begin
                case (CODE)
                    2'h1: MV = `CSD_MV_450;
                    2'h2: MV = `CSD_MV_650;
                    2'h3: MV = `CSD_MV_1000;
                    default: MV = `CSD_MV_OFF;
                endcase
            end
            csd_pkg::CSD_IF_HICML: begin
                case (CODE)
                    2'h1: MV = `CSD_MV_900;
                    2'h2: MV = `CSD_MV_1200;
                    2'h3: MV = `CSD_MV_1500;
                    default: MV = `CSD_MV_OFF;
                endcase
            end
            // unsupported select: drive nothing rather than guess
            default: MV = `CSD_MV_OFF;
        endcase
    end
endmodule
`default_nettype wire

// ===== core/csd_pkg.sv
`include "csd_defs.svh"
package csd_pkg;
    typedef enum logic [1:0] {
        CSD_M_FOUR = 2'h0,
        CSD_M_TWO = 2'h1,
        CSD_M_JTAG = 2'h2,
        CSD_M_HARD = 2'h3
    } csd_mode_t;

    typedef enum logic [1:0] {
        CSD_IF_CML = 2'h0,
        CSD_IF_LVDS = 2'h1,
        CSD_IF_BAD = 2'h2,
        CSD_IF_HICML = 2'h3
    } csd_iface_t;

    typedef struct packed {
        logic load;
        logic [11:0] strap;
        logic [`CSD_NCH-1:0][7:0] octl;
        logic [7:0] gctl;
        logic [7:0] gctl2;
        logic [7:0] rdata;
        csd_mode_t mode;
        csd_iface_t iface;
        logic iface_bad;
        logic [3:0] rate;
        logic pre;
        logic eq;
        logic byp;
        logic clk_inv;
        logic [`CSD_NCH-1:0][1:0] swing;
        logic [`CSD_NCH-1:0] dat_en;
        logic [`CSD_NCH-1:0] dat_inv;
        logic [`CSD_NCH-1:0] clk_en;
        logic [`CSD_NCH-1:0][10:0] mv;
    } csd_state_t;
endpackage

// ===== testbench/csd_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module csd_board_model (
    input wire logic clock, // system clock
    input wire logic scan_req, // requested scan select level
    input wire logic [1:0] src_req, // requested control source
    input wire logic [1:0] iface_req, // requested interface type
    input wire logic [11:0] strap_req, // driven strap levels
    input wire logic [11:0] float_req, // straps left unconnected
    output var logic scan_n = 1'b1, // scan select pin
    output var logic [1:0] src = 2'h3, // control source pins
    output var logic [1:0] iface = 2'h0, // interface select pins
    output var logic [11:0] straps = 12'hfff // multifunction pins
);
    always @(posedge clock) begin
        scan_n <= scan_req;
        src <= src_req;
        // unsupported code is never strapped; last setting stays
        if (iface_req != 2'h2) begin
            iface <= iface_req;
        end
        // open straps read high through pull-ups
        straps <= strap_req | float_req;
    end
endmodule
`default_nettype wire

// ===== testbench/tb_control_mode_and_strap_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.svh"
module tb_control_mode_and_strap_decoder;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic scan_q = 1'b1;
    logic [1:0] src_q = 2'h3;
    logic [1:0] if_q = 2'h0;
    logic [11:0] mf_q = 12'h000;
    logic [11:0] fl_q = 12'h000;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic scan_n, jtag, hard, iunsup, pre, eq, byp, cinv;
    logic [1:0] src, ifsel, cmode, itype, lv;
    logic [11:0] straps, m;
    logic [7:0] rdata, swing;
    logic [3:0] rate, den, dinv, cen;
    logic [43:0] smv;
    logic [11:0] mfs [4] = '{12'h685, 12'h97a, 12'h400, 12'h000};
    logic [11:0] fls [4] = '{12'h000, 12'h000, 12'h000, 12'hfff};
    logic [1:0] ifs [4] = '{2'h0, 2'h1, 2'h0, 2'h3};
    logic [1:0] msel [3] = '{2'h3, 2'h1, 2'h0};
    logic [1:0] isel [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int err_count = 0;
    int total_checks = 0;

    always #10 clock = ~clock;

    csd_board_model board (.clock(clock), .scan_req(scan_q), .src_req(src_q),
        .iface_req(if_q), .strap_req(mf_q), .float_req(fl_q),
        .scan_n(scan_n), .src(src), .iface(ifsel), .straps(straps));

    csd_ctrl_decoder DUT (.CLOCK(clock), .RST(rst),
        .BOUNDARY_SCAN_SELECT_N(scan_n), .CTRL_SOURCE_SEL(src),
        .OUTPUT_MODE_SEL(ifsel), .MULTIFUNCTION_PINS(straps),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_stb),
        .REG_RD(rd_stb), .REG_RDATA(rdata), .CONTROL_MODE(cmode),
        .JTAG_MODE(jtag), .HARDWIRED_MODE(hard), .INTERFACE_TYPE(itype),
        .INTERFACE_UNSUPPORTED(iunsup), .LINE_RATE(rate),
        .PREEMPHASIS_EN(pre), .EQUALIZER_EN(eq), .RETIMER_BYPASS(byp),
        .CLOCK_INVERT(cinv), .SWING_LEVEL(swing), .SWING_MV(smv),
        .DATA_OUT_EN(den), .DATA_INVERT(dinv), .CLOCK_OUT_EN(cen));

    function automatic logic [10:0] mv(input logic [1:0] t,
                                       input logic [1:0] c);
        case ({t, c})
            4'h1: return `CSD_MV_550;
            4'h2: return `CSD_MV_900;
            4'h3: return `CSD_MV_1200;
            4'h5: return `CSD_MV_450;
            4'h6: return `CSD_MV_650;
            4'h7: return `CSD_MV_1000;
            4'hd: return `CSD_MV_900;
            4'he: return `CSD_MV_1200;
            4'hf: return `CSD_MV_1500;
            default: return `CSD_MV_OFF;
        endcase
    endfunction

    task give_verdict;
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // wait n edges, then let that edge's updates land
    task settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    task reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    initial begin
        repeat (2000) @(posedge clock);
        err_count++;
        give_verdict;
    end

    initial begin
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            rst <= 1'b1;
            mf_q <= mfs[i];
            fl_q <= fls[i];
            if_q <= ifs[i];
            repeat (8) @(posedge clock);
            rst <= 1'b0;
            settle(5);
            m = mfs[i] | fls[i];
            lv = m[9:8];
            chk({hard, cmode, itype}, {1'b1, 2'h3, ifs[i]});
            chk(rate, m[3:0]);
            chk(pre, !m[4]);
            chk(cen, (!m[5] && lv != 2'h0) ? 4'hf : 4'h0);
            chk(cinv, !m[6]);
            chk(dinv, {4{!m[7]}});
            chk(eq, !m[10]);
            chk(byp, !m[11]);
            chk({swing, den}, {{4{lv}}, lv != 2'h0 ? 4'hf : 4'h0});
            chk(smv, {4{mv(ifs[i], lv)}});
            @(posedge clock);
            mf_q <= ~mfs[i];
            fl_q <= 12'h000;
            settle(4);
            chk(rate, m[3:0]);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            scan_q <= 1'b0;
            src_q <= i[1:0];
            settle(3);
            chk({jtag, hard, cmode}, {2'h2, 2'h2});
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            scan_q <= 1'b1;
            src_q <= msel[i];
            settle(3);
            chk({jtag, hard, cmode}, {1'b0, msel[i] == 2'h3, msel[i]});
        end
        // the 10b request is held off by the board, type stays 11b
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            if_q <= isel[i];
            settle(3);
            lv = (isel[i] == 2'h2) ? 2'h3 : isel[i];
            chk({iunsup, itype}, {1'b0, lv});
            reg_rd(8'h06, {4'h0, lv, 2'h0});
        end
        chk({swing, den, dinv}, {8'hff, 4'hf, 4'h0});
        chk({rate, pre, eq, byp, cinv, cen}, 12'h000);
        reg_wr(8'h00, 8'h8c);
        reg_wr(8'h01, 8'h00);
        reg_wr(8'h02, 8'h40);
        reg_wr(8'h03, 8'hc8);
        reg_wr(8'h04, 8'hb3);
        reg_wr(8'h05, 8'h01);
        settle(3);
        chk({swing, den, dinv}, {8'hd2, 4'h1, 4'h9});
        chk(smv, {mv(2'h3, 2'h3), mv(2'h3, 2'h1), 11'h000,
                  mv(2'h3, 2'h2)});
        chk({rate, pre, eq, byp, cinv, cen},
            {4'h3, 4'he, 4'hd});
        reg_rd(8'h00, 8'h8c);
        reg_rd(8'h20, 8'h00);
        @(posedge clock);
        src_q <= 2'h3;
        settle(3);
        reg_wr(8'h04, 8'h05);
        settle(3);
        chk({rate, swing, dinv, den}, {4'hf, 8'hff, 4'h0, 4'hf});
        give_verdict;
    end
endmodule
`default_nettype wire
